// File: verilog/lrc_pkg.sv
package lrc_pkg;

	// serial frame layout: one direction bit, seven address bits, 24 data bits
	localparam int          FRAME_BITS   = 32;
	localparam int          HDR_BITS     = 8;
	localparam logic [5:0]  FRAME_LAST   = 6'h1f;
	localparam logic [5:0]  HDR_LAST     = 6'h07;
	localparam int          ADDR_W       = 7;
	localparam int          DATA_W       = 24;

	// pin index inside the synchroniser vectors
	localparam int          PIN_SCLK     = 0;
	localparam int          PIN_SEL_N    = 1;
	localparam int          PIN_SDI      = 2;

	// register addresses
	localparam logic [6:0]  LOFF_ADDR    = 7'h02;
	localparam logic [6:0]  RESP_ADDR    = 7'h03;

	// reset values and writable-bit masks (reserved bits stay zero)
	localparam logic [23:0] LOFF_RST     = 24'h000000;
	localparam logic [23:0] RESP_RST     = 24'h000000;
	localparam logic [23:0] LOFF_WMASK   = 24'he7919f;
	localparam logic [23:0] RESP_WMASK   = 24'h01ffff;

	// electrode-off detection control fields
	localparam int          LOFF_EN_BIT  = 0;
	localparam int          GSEL_BIT     = 1;
	localparam int          DCCUR_LSB    = 2;
	localparam int          ACCUR_LSB    = 7;
	localparam int          CE_EN_BIT    = 12;
	localparam int          LIMB_EN_LSB  = 15;
	localparam int          CE_PH_BIT    = 18;
	localparam int          LIMB_PH_LSB  = 21;

	// thoracic impedance control fields
	localparam int          FREQ_LSB     = 1;
	localparam int          GAIN_LSB     = 8;
	localparam int          CAP_BIT      = 12;
	localparam int          OUTSEL_BIT   = 13;
	localparam int          BYPASS_BIT   = 14;
	localparam int          SYNC_BIT     = 15;
	localparam int          ALT_BIT      = 16;

	// decode constants
	localparam logic [6:0]  DC_STEP_NA   = 7'h0a;
	localparam logic [3:0]  GAIN_MAX     = 4'ha;
	localparam logic [3:0]  GAIN_SAT     = 4'h9;
	localparam logic [9:0]  AC_TENTH_NA0 = 10'h07d;

endpackage

// File: verilog/lrc_ser_if.sv
`timescale 1ns/100ps
interface lrc_ser_if;
	logic        wr_stb;
	logic [6:0]  addr;
	logic [23:0] wdata;
	logic [23:0] rdata;

	modport ser  (output wr_stb, output addr, output wdata, input rdata);
	modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface

// File: verilog/lrc_serial.sv
`timescale 1ns/100ps
module lrc_serial
	import lrc_pkg::*;
(
	// clock, reset, enable
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic ce,
	// serial pins
	input  wire logic sclk,
	input  wire logic sel_n,
	input  wire logic sdi,
	output logic      sdo,
	output logic      sdo_oe_n,
	// register side
	lrc_ser_if.ser    bus
);
	typedef struct packed {
		logic [2:0]  s1;
		logic [2:0]  s2;
		logic [2:0]  s3;
		logic [2:0]  stab;
		logic [31:0] sh;
		logic [5:0]  cnt;
		logic        rd;
		logic        rd_pend;
		logic [6:0]  addr;
		logic [23:0] wdata;
		logic        wr_stb;
		logic [23:0] oreg;
		logic        out;
	} lrc_ser_s;

	lrc_ser_s st;
	lrc_ser_s next_st;
	logic     rise;
	logic     fall;

	// pin synchronisers, edge detection and frame shifting
	always_comb begin
		next_st = st;
		next_st.wr_stb = 1'b0;
		next_st.s1 = {sdi, sel_n, sclk};
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < 3; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.stab[i] = st.s3[i]; // level taken once stages two and three agree
			end
		end
		rise = ~st.stab[PIN_SCLK] & next_st.stab[PIN_SCLK];
		fall = st.stab[PIN_SCLK] & ~next_st.stab[PIN_SCLK];
		if (st.rd_pend) begin
			next_st.oreg = bus.rdata;
			next_st.rd_pend = 1'b0;
		end
		if (next_st.stab[PIN_SEL_N]) begin
			next_st.cnt = 6'h00;
			next_st.rd = 1'b0;
			next_st.out = 1'b0;
		end else if (rise) begin
			next_st.sh = {st.sh[30:0], next_st.stab[PIN_SDI]};
			next_st.cnt = st.cnt + 6'h01;
			if (st.cnt == HDR_LAST) begin
				next_st.addr = {st.sh[5:0], next_st.stab[PIN_SDI]};
				next_st.rd = ~st.sh[6];
				next_st.rd_pend = ~st.sh[6];
			end
			if (st.cnt == FRAME_LAST && !st.rd) begin
				next_st.wdata = {st.sh[22:0], next_st.stab[PIN_SDI]};
				next_st.wr_stb = 1'b1;
			end
		end else if (fall && st.rd) begin
			next_st.out = st.oreg[23];
			next_st.oreg = {st.oreg[22:0], 1'b0};
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
			st.s1 <= 3'h2;
			st.s2 <= 3'h2;
			st.s3 <= 3'h2;
			st.stab <= 3'h2;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign bus.wr_stb = st.wr_stb;
	assign bus.addr   = st.addr;
	assign bus.wdata  = st.wdata;
	assign sdo        = st.out;
	assign sdo_oe_n   = ~(st.rd & ~st.stab[PIN_SEL_N]);

endmodule // lrc_serial

// File: verilog/lrc_decode.sv
`timescale 1ns/100ps
module lrc_decode
	import lrc_pkg::*;
(
	// clock, reset, enable
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       ce,
	// raw fields
	input  wire logic [2:0] dc_code,
	input  wire logic [1:0] ac_code,
	input  wire logic [3:0] gain_code,
	// decoded values
	output logic [6:0]      dc_bias_na,
	output logic [9:0]      ac_excite_tenth_na,
	output logic [3:0]      amp_gain
);
	typedef struct packed {
		logic [6:0] dc;
		logic [9:0] ac;
		logic [3:0] gain;
	} lrc_dec_s;

	lrc_dec_s st;
	lrc_dec_s next_st;

	// current steps, doubling excitation and saturating gain
	always_comb begin
		next_st.dc = 7'(dc_code * DC_STEP_NA);
		next_st.ac = 10'(AC_TENTH_NA0 << ac_code);
		next_st.gain = (gain_code > GAIN_SAT) ? GAIN_MAX : gain_code + 4'h1;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign dc_bias_na         = st.dc;
	assign ac_excite_tenth_na = st.ac;
	assign amp_gain           = st.gain;

endmodule // lrc_decode

// File: verilog/lrc_regs.sv
`timescale 1ns/100ps
module lrc_regs
	import lrc_pkg::*;
(
	// clock, reset, enable
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       ce,
	// serial port pins
	input  wire logic       sclk,
	input  wire logic       sel_n,
	input  wire logic       sdi,
	output logic            sdo,
	output logic            sdo_oe_n,
	// analog-side status
	input  wire logic       cal_dac_en,
	input  wire logic       carrier_dac_msb,
	input  wire logic       pin_three_func_out,
	// electrode-off detection controls
	output logic            electrode_off_detect_enable,
	output logic            dc_detect_active,
	output logic [2:0]      dc_bias_current_code,
	output logic [6:0]      dc_bias_na,
	output logic [1:0]      ac_excite_current_code,
	output logic [9:0]      ac_excite_tenth_na,
	output logic [3:0]      ac_detect_en,
	output logic [3:0]      ac_phase_invert,
	// thoracic impedance controls
	output logic            carrier_alt_freq_mode,
	output logic [1:0]      carrier_freq_select,
	output logic            carrier_sync_out_enable,
	output logic            general_io_pin_three,
	output logic            sync_period_constant,
	output logic            ext_amp_bypass,
	output logic            carrier_cap_source,
	output logic            carrier_dac_right_arm_out,
	output logic [3:0]      thoracic_amp_gain
);
	typedef struct packed {
		logic [23:0] loff;
		logic [23:0] resp;
		logic        det_en;
		logic        dc_act;
		logic [2:0]  dc_code;
		logic [3:0]  ac_en;
		logic [3:0]  ph;
		logic        gpio;
		logic        sync_const;
		logic        right_arm;
	} lrc_regs_s;

	lrc_regs_s   st;
	lrc_regs_s   next_st;
	logic [3:0]  ac_en_w;
	logic        det_on;
	logic        gsel;
	logic        ac_allowed;
	logic [23:0] rd_mux;

	lrc_ser_if   ser_bus ();

	// serial slave
	lrc_serial u_lrc_serial (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.ce       (ce),
		.sclk     (sclk),
		.sel_n    (sel_n),
		.sdi      (sdi),
		.sdo      (sdo),
		.sdo_oe_n (sdo_oe_n),
		.bus      (ser_bus.ser)
	);

	// register readback; unmapped addresses read zero
	always_comb begin
		case (ser_bus.addr)
			LOFF_ADDR: rd_mux = st.loff & LOFF_WMASK;
			RESP_ADDR: rd_mux = st.resp & RESP_WMASK;
			default:   rd_mux = 24'h000000;
		endcase
	end
	assign ser_bus.rdata = rd_mux;

	// detection master switch and ac gating
	assign det_on     = st.loff[LOFF_EN_BIT];
	assign gsel       = det_on & st.loff[GSEL_BIT];
	assign ac_allowed = det_on & ~cal_dac_en;

	// limb electrodes: global select OR own enable (bits 15, 16, 17)
	for (genvar i = 0; i < 3; i++) begin : g_limb
		assign ac_en_w[i] = ac_allowed & (gsel | st.loff[LIMB_EN_LSB + i]);
	end
	// common electrode ignores the global select
	assign ac_en_w[3] = ac_allowed & st.loff[CE_EN_BIT];

	// register writes and derived control outputs
	always_comb begin
		next_st = st;
		if (ser_bus.wr_stb) begin
			case (ser_bus.addr)
				LOFF_ADDR: next_st.loff = ser_bus.wdata & LOFF_WMASK;
				RESP_ADDR: next_st.resp = ser_bus.wdata & RESP_WMASK;
				default:   next_st.loff = st.loff;
			endcase
		end
		next_st.det_en = det_on;
		next_st.dc_act = det_on & ~gsel;
		// bias code only while dc detection runs
		next_st.dc_code = (det_on & ~gsel) ? st.loff[DCCUR_LSB +: 3] : 3'h0;
		next_st.ac_en = ac_en_w;
		// phase invert follows the right arm, left leg, left arm, common ordering of ac_en
		next_st.ph = {st.loff[CE_PH_BIT], st.loff[LIMB_PH_LSB + 2], st.loff[LIMB_PH_LSB + 1], st.loff[LIMB_PH_LSB]};
		// general pin three carries the carrier msb when sync is on
		next_st.gpio = st.resp[SYNC_BIT] ? carrier_dac_msb : pin_three_func_out;
		next_st.sync_const = st.resp[SYNC_BIT] & st.resp[ALT_BIT];
		next_st.right_arm = st.resp[CAP_BIT] | st.resp[OUTSEL_BIT];
	end

	// state register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
			st.loff <= LOFF_RST;
			st.resp <= RESP_RST;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// numeric decode of current and gain fields
	lrc_decode u_lrc_decode (
		.clk                (clk),
		.sys_rst            (sys_rst),
		.ce                 (ce),
		.dc_code            (st.dc_code),
		.ac_code            (st.loff[ACCUR_LSB +: 2]),
		.gain_code          (st.resp[GAIN_LSB +: 4]),
		.dc_bias_na         (dc_bias_na),
		.ac_excite_tenth_na (ac_excite_tenth_na),
		.amp_gain           (thoracic_amp_gain)
	);

	// output assignments
	assign electrode_off_detect_enable = st.det_en;
	assign dc_detect_active            = st.dc_act;
	assign dc_bias_current_code        = st.dc_code;
	assign ac_excite_current_code      = st.loff[ACCUR_LSB +: 2];
	assign ac_detect_en                = st.ac_en;
	assign ac_phase_invert             = st.ph;
	assign carrier_alt_freq_mode       = st.resp[ALT_BIT];
	assign carrier_freq_select         = st.resp[FREQ_LSB +: 2];
	assign carrier_sync_out_enable     = st.resp[SYNC_BIT];
	assign general_io_pin_three        = st.gpio;
	assign sync_period_constant        = st.sync_const;
	assign ext_amp_bypass              = st.resp[BYPASS_BIT];
	assign carrier_cap_source          = st.resp[CAP_BIT];
	assign carrier_dac_right_arm_out   = st.right_arm;

endmodule // lrc_regs

// File: bench/lrc_regs_assertions.sv
`timescale 1ns/100ps
module lrc_regs_assertions (
	// clock and reset
	input wire logic       clk,
	input wire logic       sys_rst,
	// analog-side inputs
	input wire logic       cal_dac_en,
	input wire logic       carrier_dac_msb,
	input wire logic       pin_three_func_out,
	// detection controls
	input wire logic       electrode_off_detect_enable,
	input wire logic       dc_detect_active,
	input wire logic [2:0] dc_bias_current_code,
	input wire logic [6:0] dc_bias_na,
	input wire logic [1:0] ac_excite_current_code,
	input wire logic [9:0] ac_excite_tenth_na,
	input wire logic [3:0] ac_detect_en,
	// thoracic controls
	input wire logic       carrier_sync_out_enable,
	input wire logic       general_io_pin_three,
	input wire logic       carrier_cap_source,
	input wire logic       carrier_dac_right_arm_out
);
	logic [2:0] age;
	// cycles since reset release; masks the decode pipeline refill
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			age <= 3'h0;
		end else if (age != 3'h7) begin
			age <= age + 3'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_dc_code;
		!dc_detect_active |-> dc_bias_current_code == 3'h0;
	endproperty
	a_dc_code: assert property (p_dc_code) else $error("dc code while dc off");
	property p_dc_na;
		(age == 3'h7 && $stable(dc_bias_current_code))[*3] |-> dc_bias_na == dc_bias_current_code * 7'h0a;
	endproperty
	a_dc_na: assert property (p_dc_na) else $error("dc current decode");
	property p_ac_na;
		(age == 3'h7 && $stable(ac_excite_current_code))[*3] |-> ac_excite_tenth_na == (10'h07d << ac_excite_current_code);
	endproperty
	a_ac_na: assert property (p_ac_na) else $error("ac current decode");
	property p_off;
		!electrode_off_detect_enable && !$past(electrode_off_detect_enable) |-> ac_detect_en == 4'h0 && !dc_detect_active;
	endproperty
	a_off: assert property (p_off) else $error("detection while disabled");
	property p_cal;
		$past(cal_dac_en) |-> ac_detect_en == 4'h0;
	endproperty
	a_cal: assert property (p_cal) else $error("ac detect with cal dac on");
	property p_global_ac_detect_select;
		electrode_off_detect_enable && $past(electrode_off_detect_enable) && !dc_detect_active && !$past(cal_dac_en)
			|-> ac_detect_en[2:0] == 3'h7;
	endproperty
	a_global_ac_detect_select: assert property (p_global_ac_detect_select) else $error("global ac select not applied");
	property p_pin;
		age == 3'h7 |-> general_io_pin_three ==
			($past(carrier_sync_out_enable) ? $past(carrier_dac_msb) : $past(pin_three_func_out));
	endproperty
	a_pin: assert property (p_pin) else $error("pin three source");
	property p_cap;
		carrier_cap_source |=> carrier_dac_right_arm_out;
	endproperty
	a_cap: assert property (p_cap) else $error("external caps without right arm path");
endmodule // lrc_regs_assertions
bind lrc_regs lrc_regs_assertions u_lrc_regs_assertions (
	.clk, .sys_rst, .cal_dac_en, .carrier_dac_msb, .pin_three_func_out,
	.electrode_off_detect_enable, .dc_detect_active, .dc_bias_current_code, .dc_bias_na,
	.ac_excite_current_code, .ac_excite_tenth_na, .ac_detect_en, .carrier_sync_out_enable,
	.general_io_pin_three, .carrier_cap_source, .carrier_dac_right_arm_out
);

// File: bench/lrc_host.sv
`timescale 1ns/100ps
module lrc_host (
	// clock
	input  wire logic clk,
	// serial pins
	output logic      sclk,
	output logic      sel_n,
	output logic      sdi,
	input  wire logic sdo
);
	// idle bus: select high, clock low
	initial begin
		sclk = 1'b0;
		sel_n = 1'b1;
		sdi = 1'b0;
	end
	// one 32-bit mode 0 frame, clock high eight cycles and low nine to cover synchroniser lag;
	// frames go out as given, callers keep reserved positions zero except on purpose
	task automatic xfer(input logic wr, input logic [6:0] a, input logic [23:0] d, output logic [23:0] q);
		logic [31:0] f;
		f = {wr, a, d};
		q = 24'h0;
		@(posedge clk) sel_n <= 1'b0;
		for (int i = 31; i >= 0; i--) begin
			@(posedge clk) sdi <= f[i];
			repeat (8) @(posedge clk);
			sclk <= 1'b1;
			if (i < 24) q[i] = sdo; // read data taken at the rising edge
			repeat (8) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (8) @(posedge clk);
		sel_n <= 1'b1;
		sdi <= ~sdi; // released line does not keep its last value
		repeat (8) @(posedge clk);
	endtask
endmodule // lrc_host

// File: bench/test_leadoff_resp_ctrl_regs.sv
`timescale 1ns/100ps
module test_leadoff_resp_ctrl_regs;
	import lrc_pkg::*;
	logic       clk, sys_rst, ce, sclk, sel_n, sdi, sdo, sdo_oe_n, sdo_line, cal_dac_en, carrier_dac_msb;
	logic       electrode_off_detect_enable, dc_detect_active, carrier_alt_freq_mode, carrier_sync_out_enable;
	logic       general_io_pin_three, sync_period_constant, ext_amp_bypass, carrier_cap_source;
	logic       carrier_dac_right_arm_out, pin_three_func_out;
	logic [2:0] dc_bias_current_code;
	logic [6:0] dc_bias_na;
	logic [1:0] ac_excite_current_code, carrier_freq_select;
	logic [9:0] ac_excite_tenth_na;
	logic [3:0] ac_detect_en, thoracic_amp_gain, ac_phase_invert;
	int         err_total = 0;
	int         samples_checked = 0;
	lrc_regs u_lrc_regs (.clk, .sys_rst, .ce, .sclk, .sel_n, .sdi, .sdo, .sdo_oe_n, .cal_dac_en,
		.carrier_dac_msb, .pin_three_func_out, .electrode_off_detect_enable, .dc_detect_active,
		.dc_bias_current_code, .dc_bias_na, .ac_excite_current_code, .ac_excite_tenth_na, .ac_detect_en,
		.ac_phase_invert, .carrier_alt_freq_mode, .carrier_freq_select, .carrier_sync_out_enable,
		.general_io_pin_three, .sync_period_constant, .ext_amp_bypass, .carrier_cap_source,
		.carrier_dac_right_arm_out, .thoracic_amp_gain);
	// a released data out line shows the inverse of its last driven value
	assign sdo_line = sdo_oe_n ? ~sdo : sdo;
	lrc_host u_lrc_host (.clk, .sclk, .sel_n, .sdi, .sdo(sdo_line));
	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic ck(input logic ok);
		samples_checked++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("CHECK FAILED at %0t: value mismatch", $time);
		end
	endtask
	task automatic tally_and_finish;
		if (err_total == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// register write, then let the decode pipeline settle
	task automatic wr(input logic [6:0] a, input logic [23:0] d);
		logic [23:0] q;
		u_lrc_host.xfer(1'b1, a, d, q);
		repeat (4) @(posedge clk);
	endtask
	task automatic rd(input logic [6:0] a, input logic [23:0] e);
		logic [23:0] q;
		u_lrc_host.xfer(1'b0, a, 24'h0, q);
		ck(q === e && sdo_oe_n === 1'b1);
	endtask
	task automatic t_reset;
		rd(LOFF_ADDR, 24'h000000);
		rd(RESP_ADDR, 24'h000000);
		ck(thoracic_amp_gain === 4'h1 && ac_excite_tenth_na === 10'h07d && ac_detect_en === 4'h0);
	endtask
	task automatic t_reserved;
		wr(LOFF_ADDR, 24'hffffff);
		rd(LOFF_ADDR, 24'he7919f);
		ck(dc_bias_current_code === 3'h0 && ac_detect_en === 4'hf && !dc_detect_active);
		wr(LOFF_ADDR, 24'hb40000);
		rd(LOFF_ADDR, 24'ha40000);
		ck(ac_phase_invert === 4'hd && ac_detect_en === 4'h0);
		wr(RESP_ADDR, 24'hffffff);
		rd(RESP_ADDR, 24'h01ffff);
		ck(thoracic_amp_gain === 4'ha && sync_period_constant === 1'b1);
		wr(7'h05, 24'hffffff);
		rd(7'h05, 24'h000000);
	endtask
	task automatic t_detect;
		for (int c = 0; c < 8; c++) begin
			wr(LOFF_ADDR, 24'h008001 | (24'(c) << 2));
			ck(dc_detect_active === 1'b1 && dc_bias_na === 7'(c) * 7'h0a && ac_detect_en === 4'h1);
		end
		wr(LOFF_ADDR, 24'h000003);
		ck(ac_detect_en === 4'h7 && dc_bias_na === 7'h00);
		@(posedge clk) cal_dac_en <= 1'b1;
		repeat (4) @(posedge clk);
		ck(ac_detect_en === 4'h0);
		@(posedge clk) cal_dac_en <= 1'b0;
		wr(LOFF_ADDR, 24'h039002);
		ck(ac_detect_en === 4'h0 && electrode_off_detect_enable === 1'b0);
		for (int c = 0; c < 4; c++) begin
			wr(LOFF_ADDR, 24'(c) << 7);
			ck(ac_excite_current_code === 2'(c) && ac_excite_tenth_na === (10'h07d << c));
		end
	endtask
	task automatic t_resp;
		for (int c = 0; c < 16; c++) begin
			wr(RESP_ADDR, 24'(c) << 8);
			ck(thoracic_amp_gain === ((c > 9) ? 4'ha : 4'(c) + 4'h1));
		end
		wr(RESP_ADDR, 24'h01c006);
		ck(carrier_alt_freq_mode && carrier_freq_select === 2'h3 && ext_amp_bypass && sync_period_constant);
		@(posedge clk) carrier_dac_msb <= 1'b1;
		repeat (3) @(posedge clk);
		ck(general_io_pin_three === 1'b1);
		@(posedge clk) begin
			carrier_dac_msb <= 1'b0;
			pin_three_func_out <= 1'b1;
		end
		repeat (3) @(posedge clk);
		ck(general_io_pin_three === 1'b0);
		wr(RESP_ADDR, 24'h001000);
		ck(carrier_cap_source === 1'b1 && carrier_dac_right_arm_out === 1'b1 && general_io_pin_three === 1'b1);
		wr(RESP_ADDR, 24'h000000);
		ck(carrier_cap_source === 1'b0 && carrier_dac_right_arm_out === 1'b0);
		wr(RESP_ADDR, 24'h002000);
		ck(carrier_dac_right_arm_out === 1'b1);
		wr(RESP_ADDR, 24'h008002);
		ck(carrier_sync_out_enable === 1'b1 && sync_period_constant === 1'b0 && carrier_alt_freq_mode === 1'b0);
		ck(carrier_freq_select === 2'h1 && carrier_dac_right_arm_out === 1'b0);
	endtask
	// reset in mid-run returns both registers and the detection controls to zero
	task automatic t_rerst;
		wr(LOFF_ADDR, 24'h008005);
		wr(RESP_ADDR, 24'h01ffff);
		@(posedge clk) sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk);
		ck(electrode_off_detect_enable === 1'b0 && ac_detect_en === 4'h0 && dc_bias_current_code === 3'h0);
		rd(LOFF_ADDR, 24'h000000);
		rd(RESP_ADDR, 24'h000000);
	endtask
	// watchdog well beyond the expected run length
	initial begin
		repeat (90000) @(posedge clk);
		err_total++;
		tally_and_finish();
	end
	// reset, then the scenarios in turn
	initial begin
		sys_rst = 1'b1;
		ce = 1'b1;
		cal_dac_en = 1'b0;
		carrier_dac_msb = 1'b0;
		pin_three_func_out = 1'b0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_reset();
		t_reserved();
		t_detect();
		t_resp();
		t_rerst();
		tally_and_finish();
	end
endmodule // test_leadoff_resp_ctrl_regs
